// ### logic/uirq_pkg.sv
// Summary of operation
// R1: Any change of the auto-request status raises the group-2 interrupt output.
// R2: Auto-request status is read-only, byte wide; writes leave it unchanged.
// R3: Firmware reads auto-request status on group-2 interrupt to find the source.
// R4: Writing zero to an auto-request clear bit forces that status bit to zero; here a set-interface event with the endpoint valid in the same cycle keeps it set.
// R5: Endpoint-related status bits are invalid unless endpoint enabled and interface active.
// R6: A one in bus-event mask suppresses that source from the group-0 interrupt.
// R7: Mask registers read back the last byte written; here unused bits (bus 5..3, ep0 7) read back as zero.
// R8: Bus mask bits 7,6,2,1,0: reset, resume/suspend, set, clear, halt; 5..3 zero.
// R9: A one in control-endpoint mask suppresses that source from group-0 interrupt.
// R10: Ep0 mask bits 6..0: in, in data, out data, success, stall, protect, decode.
// R11: All mask bits reset to zero, every source unmasked.
// R12: Clear registers are write-only and always read as all ones.
// R13: Writing zero clears a source; clear bit self-returns to one; one does nothing.
// R14: Auto-request bit 5 sets when hardware processes a set-interface request.
// R15: Masked sources are still recorded; masking only gates the interrupt output.
package uirq_pkg;
    localparam logic [15:0] ADDR_STATUS_AUTO = 16'hff2b;
    localparam logic [15:0] ADDR_MASK_BUS = 16'hff37;
    localparam logic [15:0] ADDR_MASK_EP0 = 16'hff38;
    localparam logic [15:0] ADDR_STATUS_BUS = 16'hff28;
    localparam logic [15:0] ADDR_STATUS_EP0 = 16'hff29;
    localparam logic [15:0] ADDR_CLEAR_BUS = 16'hff4a;
    localparam logic [15:0] ADDR_CLEAR_EP0 = 16'hff4b;
    localparam logic [15:0] ADDR_CLEAR_AUTO = 16'hff4e;
    localparam logic [15:0] ADDR_EP_ENABLE = 16'hff50;
    localparam logic [7:0] BITS_BUS = 8'hc7;
    localparam logic [7:0] BITS_EP0 = 8'h7f;
    localparam logic [7:0] BITS_AUTO = 8'h20;
    localparam logic [7:0] BITS_EP_ENABLE = 8'h01;
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] CLEAR_READ = 8'hff;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam int AUTO_SETIF_BIT = 5;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } uirq_req_t;

    typedef struct packed {
        logic [7:0] bus;
        logic [7:0] ep0;
        logic auto_setif;
    } uirq_evt_t;
endpackage

// ### logic/uirq_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module uirq_ctrl (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire uirq_pkg::uirq_req_t i_req,
    input wire uirq_pkg::uirq_evt_t i_evt,
    input wire logic i_if_active,
    output logic [7:0] o_rdata,
    output logic o_irq_group0,
    output logic o_irq_group2
);
    logic [7:0] st_bus_q, st_bus_d;
    logic [7:0] st_ep0_q, st_ep0_d;
    logic [7:0] st_auto_q, st_auto_d;
    logic [7:0] m_bus_q;
    logic [7:0] m_ep0_q;
    logic [7:0] ep_en_q;
    logic ep_valid;
    logic [7:0] clr_bus, clr_ep0, clr_auto, set_auto;

    function automatic logic hit(input uirq_pkg::uirq_req_t r, input logic [15:0] a);
        hit = r.wr && (r.addr == a);
    endfunction

    // Zero bits of a clear write; a one has no effect
    function automatic logic [7:0] clr_of(input uirq_pkg::uirq_req_t r, input logic [15:0] a,
        input logic [7:0] bits);
        clr_of = hit(r, a) ? (~r.wdata & bits) : 8'h00;
    endfunction

    assign ep_valid = ep_en_q[0] && i_if_active;
    // R13: clear zero bits
    assign clr_bus = clr_of(i_req, uirq_pkg::ADDR_CLEAR_BUS, uirq_pkg::BITS_BUS);
    assign clr_ep0 = clr_of(i_req, uirq_pkg::ADDR_CLEAR_EP0, uirq_pkg::BITS_EP0);
    assign clr_auto = clr_of(i_req, uirq_pkg::ADDR_CLEAR_AUTO, uirq_pkg::BITS_AUTO);
    // R14: auto set-interface event
    // R5: gated by endpoint validity
    assign set_auto = (i_evt.auto_setif && ep_valid) ? uirq_pkg::BITS_AUTO : 8'h00;

    // R15: record regardless of mask
    // Set beats a simultaneous clear so no event is lost
    assign st_bus_d = ((st_bus_q & ~clr_bus) | i_evt.bus) & uirq_pkg::BITS_BUS;
    assign st_ep0_d = ((st_ep0_q & ~clr_ep0) | i_evt.ep0) & uirq_pkg::BITS_EP0;
    // R4: clear zeroes bit 5 unless set_auto fires in the same cycle
    // R2: no write path to status
    assign st_auto_d = ((st_auto_q & ~clr_auto) | set_auto) & uirq_pkg::BITS_AUTO;

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_bus_q <= uirq_pkg::RST_REG;
            st_ep0_q <= uirq_pkg::RST_REG;
            st_auto_q <= uirq_pkg::RST_REG;
        end else begin
            st_bus_q <= st_bus_d;
            st_ep0_q <= st_ep0_d;
            st_auto_q <= st_auto_d;
        end
    end

    // R11: masks reset unmasked
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            m_bus_q <= uirq_pkg::RST_REG;
            m_ep0_q <= uirq_pkg::RST_REG;
            ep_en_q <= uirq_pkg::RST_REG;
        end else begin
            // R7: byte-wide mask writes
            // R8: unused bus bits held zero
            if (hit(i_req, uirq_pkg::ADDR_MASK_BUS)) begin
                m_bus_q <= i_req.wdata & uirq_pkg::BITS_BUS;
            end
            // R10: bit 7 held zero
            if (hit(i_req, uirq_pkg::ADDR_MASK_EP0)) begin
                m_ep0_q <= i_req.wdata & uirq_pkg::BITS_EP0;
            end
            if (hit(i_req, uirq_pkg::ADDR_EP_ENABLE)) begin
                ep_en_q <= i_req.wdata & uirq_pkg::BITS_EP_ENABLE;
            end
        end
    end

    // Registered outputs; group-0 interrupt lags status by one cycle, group 2 rises with it
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_irq_group0 <= 1'b0;
            o_irq_group2 <= 1'b0;
        end else begin
            // R6: bus mask gates group 0
            // R9: ep0 mask gates group 0
            o_irq_group0 <= |(st_bus_q & ~m_bus_q) || |(st_ep0_q & ~m_ep0_q);
            // R1: change or pending raises group 2
            o_irq_group2 <= (st_auto_d != st_auto_q) || (st_auto_q != 8'h00);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= uirq_pkg::RST_REG;
        end else if (i_req.rd) begin
            unique case (i_req.addr)
                uirq_pkg::ADDR_STATUS_AUTO: o_rdata <= st_auto_q;
                uirq_pkg::ADDR_STATUS_BUS: o_rdata <= st_bus_q;
                uirq_pkg::ADDR_STATUS_EP0: o_rdata <= st_ep0_q;
                uirq_pkg::ADDR_MASK_BUS: o_rdata <= m_bus_q;
                uirq_pkg::ADDR_MASK_EP0: o_rdata <= m_ep0_q;
                uirq_pkg::ADDR_EP_ENABLE: o_rdata <= ep_en_q;
                // R12: clear registers read ones
                uirq_pkg::ADDR_CLEAR_BUS,
                uirq_pkg::ADDR_CLEAR_EP0,
                uirq_pkg::ADDR_CLEAR_AUTO: o_rdata <= uirq_pkg::CLEAR_READ;
                default: o_rdata <= uirq_pkg::UNMAPPED_READ;
            endcase
        end else begin
            o_rdata <= uirq_pkg::RST_REG;
        end
    end

    sequence s_wr_mask_bus;
        i_req.wr && i_req.addr == uirq_pkg::ADDR_MASK_BUS;
    endsequence

    sequence s_rd_mask_bus;
        i_req.rd && i_req.addr == uirq_pkg::ADDR_MASK_BUS;
    endsequence

    sequence s_clear_auto_zero;
        i_req.wr && i_req.addr == uirq_pkg::ADDR_CLEAR_AUTO && !i_req.wdata[5]
            && !(i_evt.auto_setif && ep_valid);
    endsequence

    AST_GRP2_ON_CHANGE: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n) // R1
        (st_auto_d != st_auto_q) |=> o_irq_group2)
        else $error("group-2 interrupt missed a status change");

    AST_STATUS_RO: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n) // R2
        (i_req.wr && i_req.addr == uirq_pkg::ADDR_STATUS_AUTO && !i_evt.auto_setif)
        |=> $stable(st_auto_q))
        else $error("write changed read-only status");

    AST_CLEAR_FORCES_ZERO: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n) // R4
        s_clear_auto_zero |=> st_auto_q[5] == 1'b0)
        else $error("auto status not cleared by zero write");

    AST_EP_INVALID: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n) // R5
        (!ep_valid && st_auto_q == 8'h00) |=> st_auto_q == 8'h00)
        else $error("status set while endpoint invalid");

    AST_MASK_GATES: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n) // R6
        ((st_bus_q & ~m_bus_q) == 8'h00 && (st_ep0_q & ~m_ep0_q) == 8'h00)
        |=> !o_irq_group0)
        else $error("masked source raised group-0 interrupt");

    AST_MASK_READBACK: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n) // R7
        s_wr_mask_bus ##1 (s_rd_mask_bus and !i_req.wr)
        |=> o_rdata == ($past(i_req.wdata, 2) & uirq_pkg::BITS_BUS))
        else $error("bus mask readback differs from write");

    AST_EP0_MASK_TOP_ZERO: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n) // R10
        i_req.rd && i_req.addr == uirq_pkg::ADDR_MASK_EP0 |=> o_rdata[7] == 1'b0)
        else $error("ep0 mask bit 7 read nonzero");

    AST_CLEAR_READS_ONES: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n) // R12
        i_req.rd && i_req.addr == uirq_pkg::ADDR_CLEAR_BUS |=> o_rdata == 8'hff)
        else $error("clear register did not read all ones");

    AST_SETIF_SETS: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n) // R14
        (i_evt.auto_setif && ep_valid) |=> st_auto_q[5] ##1 o_irq_group2)
        else $error("set-interface event not recorded");

    AST_MASKED_RECORDED: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n) // R15
        (i_evt.bus[7] && m_bus_q[7]) |=> st_bus_q[7])
        else $error("masked bus reset event not recorded");
endmodule
`default_nettype wire

// ### bench/test_usb_function_irq_status_mask.sv
`timescale 1ns/100ps
`default_nettype none
module test_usb_function_irq_status_mask;
    logic i_ref_clk = 1'b0;
    logic i_arst_n = 1'b0;
    uirq_pkg::uirq_req_t i_req = '0;
    uirq_pkg::uirq_evt_t i_evt = '0;
    logic i_if_active = 1'b0;
    logic [7:0] o_rdata;
    logic o_irq_group0;
    logic o_irq_group2;
    int miscompares = 0;
    int cmp_count = 0;
    uirq_pkg::uirq_evt_t ev;

    always #25 i_ref_clk = ~i_ref_clk;

    uirq_ctrl uut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_req(i_req), .i_evt(i_evt),
        .i_if_active(i_if_active), .o_rdata(o_rdata), .o_irq_group0(o_irq_group0),
        .o_irq_group2(o_irq_group2));

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_req.addr <= a;
        i_req.wdata <= d;
        i_req.wr <= 1'b1;
        @(posedge i_ref_clk);
        i_req.wr <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
        @(posedge i_ref_clk);
        i_req.addr <= a;
        i_req.rd <= 1'b1;
        @(posedge i_ref_clk);
        i_req.rd <= 1'b0;
        #1;
        chk(o_rdata, exp);
    endtask

    // One-cycle event, returns once the interrupt has settled
    task automatic pulse(input uirq_pkg::uirq_evt_t e);
        @(posedge i_ref_clk);
        i_evt <= e;
        @(posedge i_ref_clk);
        i_evt <= '0;
        @(posedge i_ref_clk);
        #1;
    endtask

    task automatic src_test(input logic g, input int b);
        logic [7:0] bv;
        logic [7:0] all_v;
        logic [15:0] ma;
        logic [15:0] sa;
        logic [15:0] ca;
        bv = 8'h01 << b;
        all_v = g ? uirq_pkg::BITS_EP0 : uirq_pkg::BITS_BUS;
        ma = g ? uirq_pkg::ADDR_MASK_EP0 : uirq_pkg::ADDR_MASK_BUS;
        sa = g ? uirq_pkg::ADDR_STATUS_EP0 : uirq_pkg::ADDR_STATUS_BUS;
        ca = g ? uirq_pkg::ADDR_CLEAR_EP0 : uirq_pkg::ADDR_CLEAR_BUS;
        ev = '0;
        ev.bus = g ? 8'h00 : bv;
        ev.ep0 = g ? bv : 8'h00;
        pulse(ev);
        chk({7'h00, o_irq_group0}, 8'h00);
        rd_reg(sa, bv);
        wr_reg(ca, 8'hff);
        rd_reg(sa, bv);
        wr_reg(ma, all_v & ~bv);
        rd_reg(ca, 8'hff);
        chk({7'h00, o_irq_group0}, 8'h01);
        wr_reg(ca, ~bv);
        rd_reg(sa, 8'h00);
        chk({7'h00, o_irq_group0}, 8'h00);
        wr_reg(ma, all_v);
    endtask

    initial begin
        repeat (2) @(posedge i_ref_clk);
        i_arst_n <= 1'b1;
        rd_reg(uirq_pkg::ADDR_MASK_BUS, 8'h00);
        rd_reg(uirq_pkg::ADDR_MASK_EP0, 8'h00);
        rd_reg(uirq_pkg::ADDR_CLEAR_AUTO, 8'hff);
        rd_reg(16'hff00, uirq_pkg::UNMAPPED_READ);
        wr_reg(uirq_pkg::ADDR_MASK_BUS, 8'hff);
        rd_reg(uirq_pkg::ADDR_MASK_BUS, 8'hc7);
        wr_reg(uirq_pkg::ADDR_MASK_EP0, 8'hff);
        rd_reg(uirq_pkg::ADDR_MASK_EP0, 8'h7f);
        wr_reg(uirq_pkg::ADDR_STATUS_AUTO, 8'hff);
        rd_reg(uirq_pkg::ADDR_STATUS_AUTO, 8'h00);
        for (int i = 0; i < 8; i++) begin
            if (uirq_pkg::BITS_BUS[i]) src_test(1'b0, i);
            if (uirq_pkg::BITS_EP0[i]) src_test(1'b1, i);
        end
        ev = '0;
        ev.auto_setif = 1'b1;
        pulse(ev);
        rd_reg(uirq_pkg::ADDR_STATUS_AUTO, 8'h00);
        chk({7'h00, o_irq_group2}, 8'h00);
        wr_reg(uirq_pkg::ADDR_EP_ENABLE, 8'h01);
        i_if_active <= 1'b1;
        pulse(ev);
        chk({7'h00, o_irq_group2}, 8'h01);
        rd_reg(uirq_pkg::ADDR_STATUS_AUTO, 8'h20);
        wr_reg(uirq_pkg::ADDR_CLEAR_AUTO, 8'hdf);
        #1;
        chk({7'h00, o_irq_group2}, 8'h01);
        @(posedge i_ref_clk);
        #1;
        chk({7'h00, o_irq_group2}, 8'h00);
        rd_reg(uirq_pkg::ADDR_STATUS_AUTO, 8'h00);
        wrap_up();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        miscompares++;
        $display("MISMATCH at %0t: run did not finish", $time);
        wrap_up();
    end
endmodule
`default_nettype wire
